// >>> design/sfdl_glitch.sv
// glitch filter: passes a level only after it held for the timeout
`timescale 1ns/1ns
module sfdl_glitch
#(
  parameter int CNT_W = 10
)
(
  // clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // timeout in clock cycles and level
  input wire logic [CNT_W-1:0] tmo,
  input wire logic din,
  // filtered level
  output logic dout_ff
);

  logic last_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic nxt_last;
  logic [CNT_W-1:0] nxt_cnt;
  logic nxt_dout;

  //////////////////////////////////////////////////////////////////////////
  // restart on each change, update output at the programmed count
  always_comb
  begin
    nxt_last = last_ff;
    nxt_cnt = cnt_ff;
    nxt_dout = dout_ff;
    if (din != last_ff)
    begin
      nxt_last = din;
      nxt_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
      if (tmo == '0)
        nxt_dout = din;
    end
    else if (cnt_ff >= tmo)
      nxt_dout = last_ff;
    else
      nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  //////////////////////////////////////////////////////////////////////////
  // filter state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      last_ff <= 1'b0;
      cnt_ff <= '0;
      dout_ff <= 1'b0;
    end
    else if (ce)
    begin
      last_ff <= nxt_last;
      cnt_ff <= nxt_cnt;
      dout_ff <= nxt_dout;
    end
  end

endmodule

// >>> design/sfdl_hyst.sv
// threshold codes with hysteresis and fault mode select for one channel
`timescale 1ns/1ns
module sfdl_hyst
  import sfdl_pkg::*;
(
  // clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // programming
  input wire logic active,
  input wire sfdl_pkg::sfdl_mode_e mode,
  input wire logic [sfdl_pkg::THR_W-1:0] uv_th,
  input wire logic [sfdl_pkg::THR_W-1:0] ov_th,
  input wire logic [sfdl_pkg::HYST_W-1:0] hyst,
  // synchronised comparator results
  input wire logic below_uv,
  input wire logic above_ov,
  // comparator codes and raw fault
  output logic [sfdl_pkg::THR_W-1:0] uv_code_ff,
  output logic [sfdl_pkg::THR_W-1:0] ov_code_ff,
  output logic fault_ff
);

  logic [THR_W:0] uv_sum;
  logic [THR_W:0] ov_dif;
  logic [THR_W-1:0] nxt_uv_code;
  logic [THR_W-1:0] nxt_ov_code;
  logic nxt_fault;
  logic uv_flag;
  logic ov_flag;

  //////////////////////////////////////////////////////////////////////////
  // shift codes only while the matching fault is present
  always_comb
  begin
    uv_flag = active & below_uv;
    ov_flag = active & above_ov;
    uv_sum = {1'b0, uv_th} + {{(THR_W+1-HYST_W){1'b0}}, hyst};
    ov_dif = {1'b0, ov_th} - {{(THR_W+1-HYST_W){1'b0}}, hyst};
    nxt_uv_code = uv_th;
    nxt_ov_code = ov_th;
    if (uv_flag)
      nxt_uv_code = uv_sum[THR_W] ? THR_MAX : uv_sum[THR_W-1:0];
    if (ov_flag)
      nxt_ov_code = ov_dif[THR_W] ? THR_MIN : ov_dif[THR_W-1:0];
    case (mode)
      SFDL_MODE_UV: nxt_fault = uv_flag;
      SFDL_MODE_OV: nxt_fault = ov_flag;
      SFDL_MODE_WIN: nxt_fault = uv_flag | ov_flag;
      default: nxt_fault = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // register codes and fault
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      uv_code_ff <= RST_UV;
      ov_code_ff <= RST_OV;
      fault_ff <= 1'b0;
    end
    else if (ce)
    begin
      uv_code_ff <= nxt_uv_code;
      ov_code_ff <= nxt_ov_code;
      fault_ff <= nxt_fault;
    end
  end

endmodule

// >>> design/sfdl_pkg.sv
// constants, types and helpers shared by the supply fault detector logic
package sfdl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // channel layout
  localparam int NUM_CH = 10;
  localparam int NUM_DED = 5;
  localparam int NUM_DUAL = 5;
  localparam int CH_HV = 0; // high_voltage_input channel
  localparam int CH_IDX_W = 4;

  ////////////////////////////////////////////////////////////////////////
  // code widths
  localparam int THR_W = 8;
  localparam int HYST_W = 5;
  localparam int FILT_W = 7;
  localparam logic [THR_W-1:0] THR_MAX = 8'hff;
  localparam logic [THR_W-1:0] THR_MIN = 8'h00;
  localparam logic [HYST_W-1:0] HYST_MAX = 5'h1f;
  localparam int THR_DIV = 255;

  ////////////////////////////////////////////////////////////////////////
  // fault mode and input range
  typedef enum logic [1:0] {
    SFDL_MODE_UV,
    SFDL_MODE_OV,
    SFDL_MODE_WIN,
    SFDL_MODE_OFF
  } sfdl_mode_e;

  typedef enum logic [1:0] {
    SFDL_RANGE_ULTRA,
    SFDL_RANGE_LOW,
    SFDL_RANGE_MID,
    SFDL_RANGE_HIGH
  } sfdl_range_e;

  // range bottom and span in millivolts
  localparam int RANGE_BOT_MV [4] = '{573, 1250, 2500, 4800};
  localparam int RANGE_SPAN_MV [4] = '{802, 1750, 3500, 9600};

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int CYC_PER_US = CLK_HZ / HZ_PER_MHZ;
  localparam int FILT_MAX_US = 100;
  localparam int FILT_MAX_CYC = FILT_MAX_US * CYC_PER_US;
  localparam int CNT_W = $clog2(FILT_MAX_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam logic [3:0] REG_UV = 4'h0;
  localparam logic [3:0] REG_OV = 4'h4;
  localparam logic [3:0] REG_CFG = 4'h8;
  localparam logic [3:0] REG_FILT = 4'hc;
  localparam logic [CH_IDX_W-1:0] STATUS_IDX = 4'ha;
  localparam logic [ADR_W-1:0] STATUS_ADR = 8'ha0;

  // cfg field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_RANGE_LSB = 2;
  localparam int CFG_DIG_BIT = 4;
  localparam int CFG_HYST_LSB = 8;
  // status field positions
  localparam int ST_FAULT_LSB = 0;
  localparam int ST_DIG_LSB = 16;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [THR_W-1:0] RST_UV = 8'h00;
  localparam logic [THR_W-1:0] RST_OV = 8'hff;
  localparam logic [HYST_W-1:0] RST_HYST = 5'h00;
  localparam logic [FILT_W-1:0] RST_FILT = 7'h00;

  // threshold voltage in mV for a range and code
  function automatic int sfdl_thr_mv(sfdl_range_e r, logic [THR_W-1:0] n);
    return RANGE_BOT_MV[r] + (RANGE_SPAN_MV[r] * int'(n)) / THR_DIV;
  endfunction

  // hysteresis voltage in mV for a range and code
  function automatic int sfdl_hyst_mv(sfdl_range_e r, logic [HYST_W-1:0] n);
    return (RANGE_SPAN_MV[r] * int'(n)) / THR_DIV;
  endfunction

endpackage

// >>> design/sfdl_top.sv
// supply fault detector bank: registers, sync, hysteresis and filters
`timescale 1ns/1ns
module sfdl_top
  import sfdl_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [sfdl_pkg::ADR_W-1:0] wb_adr,
  input wire logic [sfdl_pkg::SEL_W-1:0] wb_sel,
  input wire logic [sfdl_pkg::DAT_W-1:0] wb_dat_w,
  output logic [sfdl_pkg::DAT_W-1:0] wb_dat_r,
  output logic wb_ack,
  // comparator results from the analog front end
  input wire logic [sfdl_pkg::NUM_CH-1:0] below_uv,
  input wire logic [sfdl_pkg::NUM_CH-1:0] above_ov,
  // dual_use_input pins in digital use
  input wire logic [sfdl_pkg::NUM_DUAL-1:0] dual_use_input,
  // comparator threshold codes, channel i at [8*i +: 8]
  output logic [sfdl_pkg::NUM_CH*sfdl_pkg::THR_W-1:0] uv_code,
  output logic [sfdl_pkg::NUM_CH*sfdl_pkg::THR_W-1:0] ov_code,
  // attenuator range select, channel i at [2*i +: 2]
  output logic [2*sfdl_pkg::NUM_CH-1:0] range_sel,
  // analog enable for the dual-use channels
  output logic [sfdl_pkg::NUM_DUAL-1:0] dual_analog_en,
  // filtered results
  output logic [sfdl_pkg::NUM_CH-1:0] fault,
  output logic [sfdl_pkg::NUM_DUAL-1:0] dig_level
);

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [THR_W-1:0] uv_th_ff [NUM_CH];
  logic [THR_W-1:0] ov_th_ff [NUM_CH];
  sfdl_mode_e mode_ff [NUM_CH];
  sfdl_range_e range_ff [NUM_CH];
  logic [HYST_W-1:0] hyst_ff [NUM_CH];
  logic [FILT_W-1:0] filt_ff [NUM_CH];
  logic [NUM_CH-1:0] dig_ff;
  logic [THR_W-1:0] nxt_uv_th [NUM_CH];
  logic [THR_W-1:0] nxt_ov_th [NUM_CH];
  sfdl_mode_e nxt_mode [NUM_CH];
  sfdl_range_e nxt_range [NUM_CH];
  logic [HYST_W-1:0] nxt_hyst [NUM_CH];
  logic [FILT_W-1:0] nxt_filt [NUM_CH];
  logic [NUM_CH-1:0] nxt_dig;

  // bus state
  logic [DAT_W-1:0] nxt_dat_r;
  logic nxt_ack;
  logic take;
  logic [CH_IDX_W-1:0] acc_ch;
  logic [3:0] acc_reg;

  // pin synchronisers
  logic [NUM_CH-1:0] uv_s1_ff;
  logic [NUM_CH-1:0] uv_s2_ff;
  logic [NUM_CH-1:0] ov_s1_ff;
  logic [NUM_CH-1:0] ov_s2_ff;
  logic [NUM_DUAL-1:0] dig_s1_ff;
  logic [NUM_DUAL-1:0] dig_s2_ff;

  // detector path
  logic [NUM_CH-1:0] ch_active;
  logic [NUM_CH-1:0] raw_fault;
  logic [NUM_CH-1:0] filt_in;
  logic [NUM_CH-1:0] filt_out;
  logic [NUM_CH-1:0] nxt_fault;
  logic [NUM_DUAL-1:0] nxt_dig_level;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // true for the dual-use channels
  function automatic logic is_dual(int ch);
    return ch >= NUM_DED;
  endfunction

  // ranges each input class can attenuate
  function automatic logic range_ok(int ch, logic [1:0] r);
    if (ch == CH_HV)
      return (r == SFDL_RANGE_MID) || (r == SFDL_RANGE_HIGH);
    else if (!is_dual(ch))
      return r != SFDL_RANGE_HIGH;
    else
      return r == SFDL_RANGE_ULTRA;
  endfunction

  // power-up range for each input class
  function automatic sfdl_range_e range_rst(int ch);
    return (ch == CH_HV) ? SFDL_RANGE_MID : SFDL_RANGE_ULTRA;
  endfunction

  // timeout in us to clock cycles, limited to the maximum
  function automatic logic [CNT_W-1:0] tmo_cyc(logic [FILT_W-1:0] us);
    int lim;
    lim = (int'(us) > FILT_MAX_US) ? FILT_MAX_US : int'(us);
    return CNT_W'(lim * CYC_PER_US);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // wishbone decode: one cycle answer, unmapped reads zero
  always_comb
  begin
    take = wb_cyc & wb_stb & ~wb_ack;
    acc_ch = wb_adr[ADR_W-1:4];
    acc_reg = {wb_adr[3:2], 2'b00};
    nxt_ack = take;
    nxt_dat_r = '0;
    if (take && !wb_we)
    begin
      if (wb_adr == STATUS_ADR)
      begin
        nxt_dat_r[ST_FAULT_LSB +: NUM_CH] = fault;
        nxt_dat_r[ST_DIG_LSB +: NUM_DUAL] = dig_level;
      end
      else if (acc_ch < STATUS_IDX)
      begin
        case (acc_reg)
          REG_UV: nxt_dat_r[THR_W-1:0] = uv_th_ff[acc_ch];
          REG_OV: nxt_dat_r[THR_W-1:0] = ov_th_ff[acc_ch];
          REG_CFG:
          begin
            nxt_dat_r[CFG_MODE_LSB +: 2] = mode_ff[acc_ch];
            nxt_dat_r[CFG_RANGE_LSB +: 2] = range_ff[acc_ch];
            nxt_dat_r[CFG_DIG_BIT] = dig_ff[acc_ch];
            nxt_dat_r[CFG_HYST_LSB +: HYST_W] = hyst_ff[acc_ch];
          end
          REG_FILT: nxt_dat_r[FILT_W-1:0] = filt_ff[acc_ch];
          default: nxt_dat_r = '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes, byte lane gated
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      nxt_uv_th[i] = uv_th_ff[i];
      nxt_ov_th[i] = ov_th_ff[i];
      nxt_mode[i] = mode_ff[i];
      nxt_range[i] = range_ff[i];
      nxt_hyst[i] = hyst_ff[i];
      nxt_filt[i] = filt_ff[i];
      nxt_dig[i] = dig_ff[i];
      if (take && wb_we && acc_ch == CH_IDX_W'(i))
      begin
        case (acc_reg)
          REG_UV:
            if (wb_sel[0])
              nxt_uv_th[i] = wb_dat_w[THR_W-1:0];
          REG_OV:
            if (wb_sel[0])
              nxt_ov_th[i] = wb_dat_w[THR_W-1:0];
          REG_CFG:
          begin
            if (wb_sel[0])
            begin
              nxt_mode[i] = sfdl_mode_e'(wb_dat_w[CFG_MODE_LSB +: 2]);
              if (range_ok(i, wb_dat_w[CFG_RANGE_LSB +: 2]))
                nxt_range[i] = sfdl_range_e'(wb_dat_w[CFG_RANGE_LSB +: 2]);
              nxt_dig[i] = is_dual(i) & wb_dat_w[CFG_DIG_BIT];
            end
            if (wb_sel[1])
              nxt_hyst[i] = wb_dat_w[CFG_HYST_LSB +: HYST_W];
          end
          REG_FILT:
            if (wb_sel[0])
              nxt_filt[i] = wb_dat_w[FILT_W-1:0];
          default: nxt_hyst[i] = hyst_ff[i];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file and bus answer
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        uv_th_ff[i] <= RST_UV;
        ov_th_ff[i] <= RST_OV;
        mode_ff[i] <= SFDL_MODE_OFF;
        range_ff[i] <= range_rst(i);
        hyst_ff[i] <= RST_HYST;
        filt_ff[i] <= RST_FILT;
      end
      dig_ff <= '0;
      wb_dat_r <= '0;
      wb_ack <= 1'b0;
    end
    else if (ce)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        uv_th_ff[i] <= nxt_uv_th[i];
        ov_th_ff[i] <= nxt_ov_th[i];
        mode_ff[i] <= nxt_mode[i];
        range_ff[i] <= nxt_range[i];
        hyst_ff[i] <= nxt_hyst[i];
        filt_ff[i] <= nxt_filt[i];
      end
      dig_ff <= nxt_dig;
      wb_dat_r <= nxt_dat_r;
      wb_ack <= nxt_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for the pins
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      uv_s1_ff <= '0;
      uv_s2_ff <= '0;
      ov_s1_ff <= '0;
      ov_s2_ff <= '0;
      dig_s1_ff <= '0;
      dig_s2_ff <= '0;
    end
    else if (ce)
    begin
      uv_s1_ff <= below_uv;
      uv_s2_ff <= uv_s1_ff;
      ov_s1_ff <= above_ov;
      ov_s2_ff <= ov_s1_ff;
      dig_s1_ff <= dual_use_input;
      dig_s2_ff <= dig_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per channel detector and filter
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    // analog use only when not a digital input
    assign ch_active[g] = ~dig_ff[g];

    sfdl_hyst u_hyst (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .active(ch_active[g]),
      .mode(mode_ff[g]),
      .uv_th(uv_th_ff[g]),
      .ov_th(ov_th_ff[g]),
      .hyst(hyst_ff[g]),
      .below_uv(uv_s2_ff[g]),
      .above_ov(ov_s2_ff[g]),
      .uv_code_ff(uv_code[g*THR_W +: THR_W]),
      .ov_code_ff(ov_code[g*THR_W +: THR_W]),
      .fault_ff(raw_fault[g])
    );

    // dual-use digital level shares the same filter
    if (g >= NUM_DED)
    begin : g_dual
      assign filt_in[g] = dig_ff[g] ? dig_s2_ff[g-NUM_DED] : raw_fault[g];
    end
    else
    begin : g_ded
      assign filt_in[g] = raw_fault[g];
    end

    sfdl_glitch #(
      .CNT_W(CNT_W)
    ) u_glitch (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .tmo(tmo_cyc(filt_ff[g])),
      .din(filt_in[g]),
      .dout_ff(filt_out[g])
    );

    assign range_sel[2*g +: 2] = range_ff[g];
  end

  ////////////////////////////////////////////////////////////////////////
  // split filtered results into fault and digital level
  always_comb
  begin
    nxt_fault = filt_out & ~dig_ff;
    nxt_dig_level = filt_out[NUM_CH-1:NUM_DED] & dig_ff[NUM_CH-1:NUM_DED];
  end

  // output registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fault <= '0;
      dig_level <= '0;
      dual_analog_en <= '0;
    end
    else if (ce)
    begin
      fault <= nxt_fault;
      dig_level <= nxt_dig_level;
      dual_analog_en <= ~nxt_dig[NUM_CH-1:NUM_DED];
    end
  end

endmodule

// >>> verification/sfdl_chk.sv
// assertions on the ports of the supply fault detector bank
`timescale 1ns/1ns
module sfdl_chk
  import sfdl_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  input wire logic [sfdl_pkg::DAT_W-1:0] wb_dat_r,
  // comparators and codes
  input wire logic [sfdl_pkg::NUM_CH-1:0] below_uv,
  input wire logic [sfdl_pkg::NUM_CH-1:0] above_ov,
  input wire logic [sfdl_pkg::NUM_CH*sfdl_pkg::THR_W-1:0] uv_code,
  input wire logic [sfdl_pkg::NUM_CH*sfdl_pkg::THR_W-1:0] ov_code,
  input wire logic [2*sfdl_pkg::NUM_CH-1:0] range_sel,
  // results
  input wire logic [sfdl_pkg::NUM_DUAL-1:0] dual_analog_en,
  input wire logic [sfdl_pkg::NUM_CH-1:0] fault,
  input wire logic [sfdl_pkg::NUM_DUAL-1:0] dig_level
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // a taken request gets exactly one ack pulse
  sequence s_taken;
    wb_cyc && wb_stb && !wb_ack && ce;
  endsequence
  sequence s_pulse;
    wb_ack ##1 !wb_ack;
  endsequence
  a_ack_answer:
    assert property (s_taken |=> s_pulse)
    else $error("request not answered by one ack pulse");
  a_ack_cause:
    assert property ($rose(wb_ack) |-> $past(wb_cyc && wb_stb))
    else $error("ack without a request");
  a_dat_idle:
    assert property (!wb_ack |-> wb_dat_r == '0)
    else $error("read data outside the ack cycle");
  a_reset_vals:
    assert property ($past(rst) |-> uv_code == '0 && ov_code == '1
      && fault == '0 && range_sel == 20'h00002 && !wb_ack)
    else $error("outputs not at reset values");
  a_range_legal:
    assert property (range_sel[19:10] == 10'h000 && range_sel[1]
      && range_sel[3:2] != 2'h3 && range_sel[5:4] != 2'h3
      && range_sel[7:6] != 2'h3 && range_sel[9:8] != 2'h3)
    else $error("range not allowed for its channel");
  a_digital_quiet:
    assert property ((~dual_analog_en & ~$past(dual_analog_en)
      & fault[9:5]) == 5'h00)
    else $error("fault on a channel in digital use");
  a_analog_quiet:
    assert property ((dual_analog_en & $past(dual_analog_en)
      & dig_level) == 5'h00)
    else $error("digital level on a channel in analog use");

  // per channel: a fault needs a comparator fault, codes step by hysteresis
  for (genvar k = 0; k < NUM_CH; k++)
  begin : g_ch
    a_fault_cause:
      assert property ($rose(fault[k]) |->
        $past(below_uv[k] | above_ov[k], 4)
        || $past(below_uv[k] | above_ov[k], 5))
      else $error("fault rose without a comparator fault");
    a_code_step:
      assert property (!wb_ack && !$past(wb_ack) |->
        8'(uv_code[8*k+:8] - $past(uv_code[8*k+:8]) + 8'h1f) <= 8'h3e
        && 8'(ov_code[8*k+:8] - $past(ov_code[8*k+:8]) + 8'h1f) <= 8'h3e)
      else $error("code moved further than the hysteresis");
  end
endmodule

bind sfdl_top sfdl_chk chk (.ref_clk, .rst, .ce, .wb_cyc, .wb_stb,
  .wb_ack, .wb_dat_r, .below_uv, .above_ov, .uv_code, .ov_code,
  .range_sel, .dual_analog_en, .fault, .dig_level);

// >>> verification/sfdl_rails.sv
// supply rails seen through the analog comparators of the bank
`timescale 1ns/1ns
module sfdl_rails
  import sfdl_pkg::*;
(
  // rail voltages in mV, set by the bench
  input var int mv [sfdl_pkg::NUM_CH],
  // codes and ranges from the block
  input wire logic [sfdl_pkg::NUM_CH*sfdl_pkg::THR_W-1:0] uv_code,
  input wire logic [sfdl_pkg::NUM_CH*sfdl_pkg::THR_W-1:0] ov_code,
  input wire logic [2*sfdl_pkg::NUM_CH-1:0] range_sel,
  // comparator results
  output logic [sfdl_pkg::NUM_CH-1:0] below_uv,
  output logic [sfdl_pkg::NUM_CH-1:0] above_ov
);
  // threshold in mV: bottom plus span times code over 255
  function automatic int thr(int r, int c);
    return RANGE_BOT_MV[r] + RANGE_SPAN_MV[r] * c / THR_DIV;
  endfunction

  // comparators follow the shifted codes, so hysteresis loops through here
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      below_uv[i] = mv[i] < thr(range_sel[2*i+:2], uv_code[8*i+:8]);
      above_ov[i] = mv[i] > thr(range_sel[2*i+:2], ov_code[8*i+:8]);
    end
  end
endmodule

// >>> verification/test_sfdl_top.sv
// self-checking bench for the supply fault detector bank
`timescale 1ns/1ns
module test_sfdl_top;
  import sfdl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // ports, rails and model state
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [ADR_W-1:0] wb_adr = '0;
  logic [SEL_W-1:0] wb_sel = '0;
  logic [DAT_W-1:0] wb_dat_w = '0, wb_dat_r, q;
  logic [NUM_CH-1:0] below_uv, above_ov, fault;
  logic [NUM_DUAL-1:0] dual_use_input = '0, dual_analog_en, dig_level;
  logic [NUM_CH*THR_W-1:0] uv_code, ov_code;
  logic [2*NUM_CH-1:0] range_sel;
  int mv [NUM_CH] = '{default: 1000};
  int mismatches = 0, n_tests = 0, h, v;
  int seq [$] = '{760, 830, 900, 1300, 1200, 1100};
  int pf [5] = '{0, 2, 2, 100, 127};
  int pw [5] = '{1, 19, 21, 999, 1001};
  bit bu, ao;

  sfdl_top dut (.ref_clk, .rst, .ce, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .below_uv, .above_ov,
    .dual_use_input, .uv_code, .ov_code, .range_sel, .dual_analog_en, .fault,
    .dig_level);
  sfdl_rails rails (.mv, .uv_code, .ov_code, .range_sel, .below_uv,
    .above_ov);

  // 10 MHz clock
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // compare, bus cycles, model threshold
  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  // classic cycle, held until ack is sampled, then one idle cycle
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_w <= d;
    // only the watchdog ends a wait for ack
    do
      @(posedge ref_clk);
    while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hf);
    wb(1'b1, a, d, s);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(q, e);
  endtask

  function automatic int thr(int c);
    return RANGE_BOT_MV[0] + RANGE_SPAN_MV[0] * c / THR_DIV;
  endfunction

  // low pulse of w cycles on channel 2; fault is read at the edge
  task automatic pulse(int f, int w);
    int t, rise, fall, tc, lat;
    tc = (f > 100 ? 100 : f) * 10;
    // 2 sync, raw flop, filter register, output flop, one edge to look
    lat = tc + 6;
    wr(8'h2c, 32'(f));
    rise = -1;
    fall = -1;
    mv[2] <= 0;
    for (t = 1; t < w + tc + 20; t++)
    begin
      @(posedge ref_clk);
      if (t == w) mv[2] <= 1000;
      if (fault[2] === 1'b1 && rise < 0) rise = t;
      if (fault[2] === 1'b0 && rise >= 0 && fall < 0) fall = t;
    end
    chk(rise, w > tc ? lat : -1);
    chk(fall, w > tc ? w + lat : -1);
  endtask

  task conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(32'ha0030e48));
    dual_use_input <= 5'($urandom) | 5'h01;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // register reset values, unmapped and read-only places
    for (int c = 0; c < NUM_CH; c++)
    begin
      rd(8'(16 * c), 32'h0);
      rd(8'(16 * c + 4), 32'hff);
      rd(8'(16 * c + 8), c == 0 ? 32'hb : 32'h3);
      rd(8'(16 * c + 12), 32'h0);
    end
    wr(8'hf0, 32'hffffffff);
    rd(8'hf0, 32'h0);
    wr(STATUS_ADR, 32'hffffffff);
    rd(STATUS_ADR, 32'h0);
    wr(8'h08, 32'h13);
    rd(8'h08, 32'hb);
    wr(8'h08, 32'hf);
    rd(8'h08, 32'hf);
    chk(range_sel[1:0], 2'h3);
    // range 3 is refused on channel 1, hysteresis lane not enabled
    wr(8'h18, 32'h1f0e, 4'h1);
    rd(8'h18, 32'h2);
    // fault modes and hysteresis on channel 1, against the model
    wr(8'h10, 32'h40);
    wr(8'h14, 32'he0);
    for (int m = 0; m < 3; m++)
    begin
      h = $urandom % 32;
      mv[1] <= 1000;
      wr(8'h18, 32'(h * 256 + m));
      repeat (8) @(posedge ref_clk);
      bu = 1'b0;
      ao = 1'b0;
      for (int k = 0; k < 14; k++)
      begin
        v = k < 6 ? seq[k] : 700 + $urandom % 650;
        mv[1] <= v;
        bu = v < thr(bu ? 64 + h : 64);
        ao = v > thr(ao ? 224 - h : 224);
        repeat (12) @(posedge ref_clk);
        chk(fault[1], m == 0 ? bu : m == 1 ? ao : bu | ao);
        chk(uv_code[15:8], bu ? 64 + h : 64);
        chk(ov_code[15:8], ao ? 224 - h : 224);
      end
    end
    // glitch filter timing and suppression on channel 2
    wr(8'h28, 32'h0);
    for (int i = 0; i < 5; i++) pulse(pf[i], pw[i]);
    // channel 5 as digital input, then back to analog
    mv[5] <= 0;
    wr(8'h5c, 32'h1);
    wr(8'h58, 32'h10);
    repeat (30) @(posedge ref_clk);
    chk(fault[5], 1'b0);
    chk(dig_level[0], 1'b1);
    chk(dual_analog_en[0], 1'b0);
    wb(1'b0, STATUS_ADR, 32'h0, 4'hf);
    chk(q & 32'h00010020, 32'h00010000);
    wr(8'h58, 32'h0);
    repeat (30) @(posedge ref_clk);
    chk(dig_level[0], 1'b0);
    chk(fault[5], 1'b1);
    chk(dual_analog_en[0], 1'b1);
    // clock enable low freezes the detector, raising it lets it run on
    ce <= 1'b0;
    mv[5] <= 1000;
    repeat (20) @(posedge ref_clk);
    chk(fault[5], 1'b1);
    ce <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk(fault[5], 1'b0);
    // second reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(8'h18, 32'h3);
    conclude();
  end

  // cut a hang short; the run needs about 5000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end
endmodule
